// File: ioleli_params.svh
// offsets, widths and reset values of the line interrupt block
//
// Function
// - four modes: rising, falling, low, high
// - edge/level select writes choose detection type
// - readable per-line edge or level status
// - fall/low, rise/high select writes set polarity
// - readable per-line polarity status
// - detected condition sets line status bit
// - masked status bit only drives interrupt
// - all 32 masked requests ORed together
// - status read clears every pending bit
// - level condition keeps re-setting after reads
`ifndef IOLELI_PARAMS_SVH
`define IOLELI_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define IOLELI_OFS_EDGE_SEL   8'h00
`define IOLELI_OFS_LEVEL_SEL  8'h04
`define IOLELI_OFS_EL_STAT    8'h08
`define IOLELI_OFS_FALL_SEL   8'h0C
`define IOLELI_OFS_RISE_SEL   8'h10
`define IOLELI_OFS_POL_STAT   8'h14
`define IOLELI_OFS_MASK       8'h18
`define IOLELI_OFS_IRQ_STAT   8'h1C
`define IOLELI_OFS_IRQ_CLR    8'h20
`define IOLELI_OFS_LINE_LVL   8'h24

// ************************************************************
// widths and reset values
// ************************************************************
`define IOLELI_LINES          32
`define IOLELI_RST_EL         32'h0000_0000
`define IOLELI_RST_POL        32'h0000_0000
`define IOLELI_RST_MASK       32'h0000_0000
`define IOLELI_WARM_STAGES    3

`endif

// File: ioleli_pkg.sv
// types shared by the line interrupt block
`default_nettype none

package ioleli_pkg;

  // captured address phase of one bus transfer
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } ioleli_aphase_t;

  // per-line detection setup
  typedef struct packed {
    logic [31:0] level;
    logic [31:0] high;
  } ioleli_cfg_t;

endpackage

`default_nettype wire

// File: ioleli_top.sv
// line edge/level interrupt detector with its ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "ioleli_params.svh"

module ioleli_top
  import ioleli_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // i/o lines
  input  wire logic [31:0] line_in,
  // interrupt request
  output logic             irq
);

  // ************************************************************
  // declarations
  // ************************************************************
  ioleli_aphase_t aph_q;
  ioleli_cfg_t    cfg_q;
  ioleli_cfg_t    cfg_d;
  logic [31:0]    mask_q;
  logic [31:0]    mask_d;
  logic [31:0]    status_q;
  logic [31:0]    status_d;
  logic [31:0]    clr_w;
  logic [31:0]    sync0_q;
  logic [31:0]    sync_q;
  logic [31:0]    prev_q;
  logic [31:0]    ev;
  logic [31:0]    hrdata_q;
  logic [31:0]    rd_val;
  logic [`IOLELI_WARM_STAGES-1:0] warm_q;
  logic           warm;
  logic           acc;
  logic           rd_stat;
  logic           hreadyout_q;
  logic           hresp_q;
  logic           irq_q;

  // ************************************************************
  // input synchroniser and previous sample
  // ************************************************************

  // two-flop synchroniser, then the previous synced sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync0_q <= 32'h0000_0000;
      sync_q  <= 32'h0000_0000;
      prev_q  <= 32'h0000_0000;
    end else begin
      sync0_q <= line_in;
      sync_q  <= sync0_q;
      prev_q  <= sync_q;
    end
  end

  // blocks detection until the pipe holds real samples
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm_q <= '0;
    end else begin
      warm_q <= {warm_q[`IOLELI_WARM_STAGES-2:0], 1'b1};
    end
  end

  assign warm = warm_q[`IOLELI_WARM_STAGES-1];

  // ************************************************************
  // per-line event detector
  // ************************************************************

  // edge: compare with previous sample; level: compare with polarity
  genvar gi;
  generate
    for (gi = 0; gi < `IOLELI_LINES; gi++) begin : g_line
      logic s;
      logic p;
      logic lvl_hit;
      logic edg_hit;
      assign s       = sync_q[gi];
      assign p       = prev_q[gi];
      assign lvl_hit = cfg_q.high[gi] ? s : ~s;
      assign edg_hit = cfg_q.high[gi] ? (s & ~p)
                                      : (~s & p);
      assign ev[gi]  = warm & (cfg_q.level[gi] ? lvl_hit
                                               : edg_hit);
    end
  endgenerate

  // ************************************************************
  // ahb-lite address phase
  // ************************************************************

  // a transfer is taken when selected, non-idle and bus ready
  assign acc     = hsel & htrans[1] & hready;
  assign rd_stat = acc & ~hwrite
                 & (haddr[7:0] == `IOLELI_OFS_IRQ_STAT);

  // holds the address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
    end else begin
      aph_q.wr   <= acc & hwrite;
      aph_q.rd   <= acc & ~hwrite;
      aph_q.addr <= haddr[7:0];
    end
  end

  // zero-wait slave that always answers okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  // ************************************************************
  // register writes in the data phase
  // ************************************************************

  // next configuration from select and clear writes
  always_comb begin
    cfg_d  = cfg_q;
    mask_d = mask_q;
    clr_w  = 32'h0000_0000;
    if (aph_q.wr) begin
      unique case (aph_q.addr)
        `IOLELI_OFS_EDGE_SEL:  cfg_d.level = cfg_q.level & ~hwdata;
        `IOLELI_OFS_LEVEL_SEL: cfg_d.level = cfg_q.level | hwdata;
        `IOLELI_OFS_FALL_SEL:  cfg_d.high  = cfg_q.high & ~hwdata;
        `IOLELI_OFS_RISE_SEL:  cfg_d.high  = cfg_q.high | hwdata;
        `IOLELI_OFS_MASK:      mask_d      = hwdata;
        `IOLELI_OFS_IRQ_CLR:   clr_w       = hwdata;
        default: ;
      endcase
    end
  end

  // detection setup and mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q.level <= `IOLELI_RST_EL;
      cfg_q.high  <= `IOLELI_RST_POL;
      mask_q      <= `IOLELI_RST_MASK;
    end else begin
      cfg_q  <= cfg_d;
      mask_q <= mask_d;
    end
  end

  // ************************************************************
  // interrupt status and request
  // ************************************************************

  // new events win over read-clear and write-clear
  always_comb begin
    status_d = status_q & ~clr_w;
    if (rd_stat) begin
      status_d = 32'h0000_0000;
    end
    status_d = status_d | ev;
  end

  // sticky per-line status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
    end
  end

  // masked status bits ORed into one level request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_d);
    end
  end

  // ************************************************************
  // read data
  // ************************************************************

  // read mux; setup reads see a write still in its data phase
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      `IOLELI_OFS_EL_STAT:  rd_val = cfg_d.level;
      `IOLELI_OFS_POL_STAT: rd_val = cfg_d.high;
      `IOLELI_OFS_MASK:     rd_val = mask_d;
      `IOLELI_OFS_IRQ_STAT: rd_val = status_q;
      `IOLELI_OFS_LINE_LVL: rd_val = sync_q;
      default:              rd_val = 32'h0000_0000;
    endcase
  end

  // read data captured at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (acc & ~hwrite) begin
      hrdata_q <= rd_val;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign irq       = irq_q;

  // ************************************************************
  // checks
  // ************************************************************

  // rising edges in edge mode and low levels in level mode are caught
  AST_MODES: assert property (
    @(posedge hclk) disable iff (!hresetn)
    warm |-> ((((~cfg_q.level & cfg_q.high & sync_q & ~prev_q)
             | (cfg_q.level & ~cfg_q.high & ~sync_q)) & ~ev)
             == 32'h0000_0000))
    else $error("edge or level condition not detected");

  // falling edges in edge mode and high levels in level mode are caught
  AST_MODES_FALL_HIGH: assert property (
    @(posedge hclk) disable iff (!hresetn)
    warm |-> ((((~cfg_q.level & ~cfg_q.high & ~sync_q & prev_q)
             | (cfg_q.level & cfg_q.high & sync_q)) & ~ev)
             == 32'h0000_0000))
    else $error("falling edge or high level not detected");

  // level-select write puts lines into level mode
  AST_LEVEL_SEL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.addr == `IOLELI_OFS_LEVEL_SEL)
    |=> ((cfg_q.level & $past(hwdata)) == $past(hwdata)))
    else $error("level select write not applied");

  // edge-select write puts lines back into edge mode
  AST_EDGE_SEL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.addr == `IOLELI_OFS_EDGE_SEL)
    |=> ((cfg_q.level & $past(hwdata)) == 32'h0000_0000))
    else $error("edge select write not applied");

  // edge/level status read returns the mode bits
  AST_EL_READ: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && !hwrite && haddr[7:0] == `IOLELI_OFS_EL_STAT && !aph_q.wr)
    |=> (hrdata == cfg_q.level))
    else $error("edge/level status read wrong");

  // fall/low write clears polarity bits
  AST_FALL_SEL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.addr == `IOLELI_OFS_FALL_SEL)
    |=> ((cfg_q.high & $past(hwdata)) == 32'h0000_0000))
    else $error("fall/low select write not applied");

  // rise/high write sets polarity bits
  AST_RISE_SEL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.addr == `IOLELI_OFS_RISE_SEL)
    |=> ((cfg_q.high & $past(hwdata)) == $past(hwdata)))
    else $error("rise/high select write not applied");

  // polarity status read returns the polarity bits
  AST_POL_READ: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && !hwrite && haddr[7:0] == `IOLELI_OFS_POL_STAT && !aph_q.wr)
    |=> (hrdata == cfg_q.high))
    else $error("polarity status read wrong");

  // every event shows in status one cycle later
  AST_EVENT_SETS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ev != 32'h0000_0000) |=> ((status_q & $past(ev)) == $past(ev)))
    else $error("event did not set status");

  // no request while the mask stays empty
  AST_MASK_GATES: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (mask_q == 32'h0000_0000) [*2] |-> !irq)
    else $error("interrupt with empty mask");

  // an event on an enabled line raises the request on the next edge
  AST_EVENT_RAISES: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((ev & mask_q) != 32'h0000_0000
     && !(aph_q.wr && aph_q.addr == `IOLELI_OFS_MASK))
    |=> irq)
    else $error("enabled event did not raise interrupt");

  // request equals OR of masked status
  AST_OR_ALL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 (irq == |(status_q & mask_q)))
    else $error("interrupt is not OR of masked status");

  // a status read with no new event leaves status empty
  AST_READ_CLEARS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rd_stat && ev == 32'h0000_0000) |=> (status_q == 32'h0000_0000))
    else $error("status read did not clear");

  // a status read returns the status as it stood before the clear
  AST_STAT_READ_VALUE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_stat |=> (hrdata == $past(status_q)))
    else $error("status read returned wrong value");

  // a held level survives a status read
  AST_LEVEL_HOLDS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rd_stat && warm && (cfg_q.level & ~(cfg_q.high ^ sync_q)) != 0)
    |=> ((status_q & $past(cfg_q.level & ~(cfg_q.high ^ sync_q)))
         == $past(cfg_q.level & ~(cfg_q.high ^ sync_q))))
    else $error("level interrupt lost on read");

  // edge events only where the synced line changed
  AST_EDGE_CHANGE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 ((ev & ~cfg_q.level & ~(sync_q ^ $past(sync_q)))
         == 32'h0000_0000))
    else $error("edge event without line change");

endmodule // ioleli_top

`default_nettype wire

// File: ioleli_lines.sv
// model of the external i/o line sources and the interrupt controller
`timescale 1ns/1ps
`default_nettype none

module ioleli_lines
  import ioleli_pkg::*;
(
  // clock
  input  wire logic        hclk,
  // line levels towards the block
  output logic      [31:0] line_in,
  // interrupt request from the block
  input  wire logic        irq
);
  int   irq_rises = 0;    // rising edges seen by the controller
  logic irq_prev  = 1'b0; // request level at the previous edge

  // lines start at a quiet level before reset ends
  initial begin
    line_in = 32'h8000_000A;
  end

  // new line levels land just after a clock edge and hold till changed
  task automatic drive(input logic [31:0] v);
    @(posedge hclk);
    line_in <= v;
  endtask

  // interrupt controller counts level rises only
  always @(posedge hclk) begin
    irq_prev <= irq;
    if (irq === 1'b1 && irq_prev === 1'b0) begin
      irq_rises <= irq_rises + 1;
    end
  end
endmodule // ioleli_lines

`default_nettype wire

// File: ioleli_top_tb.sv
// self-checking bench for the line edge/level interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "ioleli_params.svh"

module ioleli_top_tb
  import ioleli_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] line_in;
  logic        irq;
  logic [31:0] rd;
  int          n_fail;
  int          samples_checked;
  int          cyc = 0;

  ioleli_top ioleli_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .line_in(line_in), .irq(irq)
  );

  ioleli_lines ioleli_lines_i (.hclk(hclk), .line_in(line_in), .irq(irq));

  // ************************************************************
  // clock, reset and hang guard
  // ************************************************************
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // a hung bus wait ends the run as a failure
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one single ahb-lite transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    rdc(`IOLELI_OFS_EL_STAT, `IOLELI_RST_EL);
    rdc(`IOLELI_OFS_POL_STAT, `IOLELI_RST_POL);
    rdc(`IOLELI_OFS_MASK, `IOLELI_RST_MASK);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0000);
    rdc(8'h30, 32'h0000_0000);
    $display("test reset values done");
    wr(`IOLELI_OFS_RISE_SEL, 32'h0000_0015);
    wr(`IOLELI_OFS_LEVEL_SEL, 32'h0000_0018);
    rdc(`IOLELI_OFS_EL_STAT, 32'h0000_0018);
    rdc(`IOLELI_OFS_POL_STAT, 32'h0000_0015);
    wr(`IOLELI_OFS_EDGE_SEL, 32'h0000_0010);
    wr(`IOLELI_OFS_EL_STAT, 32'hFFFF_FFFF);
    rdc(`IOLELI_OFS_EL_STAT, 32'h0000_0008);
    wr(`IOLELI_OFS_FALL_SEL, 32'h0000_0004);
    rdc(`IOLELI_OFS_POL_STAT, 32'h0000_0011);
    wr(`IOLELI_OFS_RISE_SEL, 32'h0000_0004);
    rdc(`IOLELI_OFS_POL_STAT, 32'h0000_0015);
    $display("test mode select done");
    ioleli_lines_i.drive(32'h8000_001D);
    settle();
    chk({31'h0, irq}, 32'h0000_0000);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0017);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0000);
    ioleli_lines_i.drive(32'h8000_000A);
    settle();
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0000);
    rdc(`IOLELI_OFS_LINE_LVL, 32'h8000_000A);
    $display("test edge events done");
    wr(`IOLELI_OFS_MASK, 32'h8000_0008);
    rdc(`IOLELI_OFS_MASK, 32'h8000_0008);
    ioleli_lines_i.drive(32'h8000_0002);
    settle();
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0008);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0008);
    ioleli_lines_i.drive(32'h8000_000A);
    settle();
    bus(1'b0, `IOLELI_OFS_IRQ_STAT, 32'h0000_0000, rd);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test level events done");
    ioleli_lines_i.drive(32'h0000_000A);
    settle();
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`IOLELI_OFS_IRQ_CLR, 32'h8000_0000);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0000);
    rdc(`IOLELI_OFS_IRQ_CLR, 32'h0000_0000);
    chk(ioleli_lines_i.irq_rises, 32'h0000_0002);
    $display("test clear register done");
    wr(`IOLELI_OFS_LEVEL_SEL, 32'h0000_0010);
    wr(`IOLELI_OFS_MASK, 32'h0000_0010);
    ioleli_lines_i.drive(32'h0000_001A);
    settle();
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0010);
    rdc(`IOLELI_OFS_IRQ_STAT, 32'h0000_0010);
    $display("test high level done");
    complete_run();
  end
endmodule // ioleli_top_tb

`default_nettype wire
